// ### pkg/flash_ctrl_pkg.sv
// Shared constants and types of the flash program/erase controller
package flash_ctrl_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_WRITE_TIMING = 8'hab;
  localparam logic [7:0] IDX_ADDRESS_LOW = 8'hac;
  localparam logic [7:0] IDX_ADDRESS_HIGH = 8'had;
  localparam logic [7:0] IDX_CONTROL_STATUS = 8'hae;
  localparam logic [7:0] IDX_WRITE_DATA_PORT = 8'haf;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hb0;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'hb1;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hb2;

  // control_status field positions
  localparam int BIT_BUSY = 7;
  localparam int BIT_WORD_WRITE_BUSY = 6;
  localparam int BIT_CONTINUOUS_READ = 4;
  localparam int BIT_WRITE = 1;
  localparam int BIT_ERASE = 0;

  // Reset values
  localparam logic [7:0] RST_WRITE_TIMING = 8'h11;
  localparam logic [7:0] RST_ADDRESS_LOW = 8'h00;
  localparam logic [7:0] RST_ADDRESS_HIGH = 8'h00;
  localparam logic [7:0] RST_WRITE_DATA = 8'h00;

  // Interrupt event bits
  localparam int IRQ_COUNT = 3;
  localparam int IRQ_ERASE_DONE = 0;
  localparam int IRQ_WORD_DONE = 1;
  localparam int IRQ_TIMEOUT = 2;

  // Timing: one generator tick lasts 16 * write_timing clocks, about 21 us
  localparam int TICK_PRESCALE = 16;
  localparam int TICK_TIME_NS = 21000;
  localparam int ERASE_TIME_NS = 20000000;
  localparam int ERASE_TICKS = (ERASE_TIME_NS + TICK_TIME_NS - 1) / TICK_TIME_NS;
  localparam int PROGRAM_TICKS = 1;
  localparam int CLK_PERIOD_NS = 5;
  localparam int WORD_TIMEOUT_NS = 40000;
  localparam int WORD_TIMEOUT_CYCLES = WORD_TIMEOUT_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WAIT_DATA, ST_PROGRAM} seq_state_t;

endpackage

// ### pkg/tick_if.sv
// Link between the sequencer and its timing generator
`timescale 1ns/1ps
interface tick_if;
  logic run;
  logic [5:0] timing;
  logic tick;
  modport gen (input run, input timing, output tick);
  modport user (output run, output timing, input tick);
endinterface

// ### logic/flash_tick_gen.sv
// Timing generator: one tick every 16 * timing clocks while running
`timescale 1ns/1ps
module flash_tick_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Sequencer side
  tick_if.gen tif
);

  logic [9:0] cnt_r;
  logic [9:0] limit;
  logic [5:0] timing_eff;

  // A zero setting would stall the sequencer forever, so it counts as one
  assign timing_eff = (tif.timing == 6'h00) ? 6'h01 : tif.timing;
  assign limit = 10'({timing_eff, 4'h0} - 10'h001);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 10'h000;
      tif.tick <= 1'b0;
    end
    else if (!tif.run)
    begin
      cnt_r <= 10'h000;
      tif.tick <= 1'b0;
    end
    else if (cnt_r == limit)
    begin
      cnt_r <= 10'h000;
      tif.tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 10'h001;
      tif.tick <= 1'b0;
    end
  end

endmodule

// ### logic/sticky_flag.sv
// One sticky status flag; a set in the clearing cycle wins
`timescale 1ns/1ps
module sticky_flag (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Event and clear
  input wire logic set,
  input wire logic clr,
  output logic flag
);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      flag <= 1'b0;
    else if (set)
      flag <= 1'b1;
    else if (clr)
      flag <= 1'b0;
  end

endmodule

// ### logic/flash_program_erase_control.sv
// Flash program/erase sequencer with Avalon-MM register access
`timescale 1ns/1ps
module flash_program_erase_control #(
  parameter int TIMEOUT_CYCLES = flash_ctrl_pkg::WORD_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Avalon-MM slave, address is the register index
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Power management
  input wire logic deep_sleep_wake,
  // Flash array
  input wire logic flash_read_req,
  output logic flash_read_en,
  output logic flash_erase_en,
  output logic flash_program_en,
  output logic [4:0] flash_page,
  output logic [8:0] flash_word,
  output logic [15:0] flash_wdata,
  // DMA and interrupt
  output logic dma_req,
  output logic irq
);

  flash_ctrl_pkg::seq_state_t state_r;
  logic ack_r;
  logic [31:0] readdata_r;
  logic [7:0] rd_mux;
  logic wr_acc;
  logic wr_low;
  logic [7:0] wr_byte;
  logic [7:0] timing_r;
  logic [7:0] addr_low_r;
  logic [7:0] addr_high_r;
  logic [7:0] data_port_r;
  logic continuous_read_enable_r;
  logic start_write_r;
  logic start_erase_r;
  logic seq_write_r;
  logic byte_phase_r;
  logic [15:0] wdata_r;
  logic [9:0] tick_cnt_r;
  logic [15:0] tmo_cnt_r;
  logic erase_en_r;
  logic program_en_r;
  logic dma_req_r;
  logic [2:0] event_r;
  logic [2:0] irq_status;
  logic [2:0] irq_clear;
  logic [2:0] irq_enable_r;
  logic data_wr;
  logic ctrl_wr;
  logic word_done;
  logic [13:0] word_addr_nxt;
  logic seq_busy;

  tick_if tif ();

  flash_tick_gen u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .tif(tif)
  );

  // Bus slave: one wait cycle, write takes effect when waitrequest is low
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_acc = avs_write & ack_r;
  assign wr_low = wr_acc & avs_byteenable[0];
  assign wr_byte = avs_writedata[7:0];
  assign avs_readdata = readdata_r;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read | avs_write) & ~ack_r;
  end

  always_comb
  begin
    rd_mux = 8'h00;
    unique case (avs_address)
      flash_ctrl_pkg::IDX_WRITE_TIMING: rd_mux = timing_r;
      flash_ctrl_pkg::IDX_ADDRESS_LOW: rd_mux = addr_low_r;
      flash_ctrl_pkg::IDX_ADDRESS_HIGH: rd_mux = addr_high_r;
      flash_ctrl_pkg::IDX_CONTROL_STATUS:
      begin
        rd_mux[flash_ctrl_pkg::BIT_BUSY] = seq_busy;
        rd_mux[flash_ctrl_pkg::BIT_WORD_WRITE_BUSY] = program_en_r;
        rd_mux[flash_ctrl_pkg::BIT_CONTINUOUS_READ] = continuous_read_enable_r;
      end
      flash_ctrl_pkg::IDX_WRITE_DATA_PORT: rd_mux = data_port_r;
      flash_ctrl_pkg::IDX_IRQ_STATUS: rd_mux = {5'h00, irq_status};
      flash_ctrl_pkg::IDX_IRQ_ENABLE: rd_mux = {5'h00, irq_enable_r};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      readdata_r <= 32'h00000000;
    else if (avs_read & ~ack_r)
      readdata_r <= {24'h000000, rd_mux};
  end

  assign ctrl_wr = wr_low & (avs_address == flash_ctrl_pkg::IDX_CONTROL_STATUS);
  assign data_wr = wr_low & (avs_address == flash_ctrl_pkg::IDX_WRITE_DATA_PORT);
  assign seq_busy = (state_r != flash_ctrl_pkg::ST_IDLE);

  // Configuration registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      timing_r <= flash_ctrl_pkg::RST_WRITE_TIMING;
      continuous_read_enable_r <= 1'b0;
      data_port_r <= flash_ctrl_pkg::RST_WRITE_DATA;
    end
    else
    begin
      if (wr_low && avs_address == flash_ctrl_pkg::IDX_WRITE_TIMING)
        timing_r <= wr_byte;
      if (ctrl_wr)
        continuous_read_enable_r <= wr_byte[flash_ctrl_pkg::BIT_CONTINUOUS_READ];
      if (data_wr)
        data_port_r <= wr_byte;
    end
  end

  // Address registers; they step after each word so a timeout leaves the failing word
  assign word_addr_nxt = 14'({addr_high_r[5:0], addr_low_r} + 14'h0001);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      addr_low_r <= flash_ctrl_pkg::RST_ADDRESS_LOW;
      addr_high_r <= flash_ctrl_pkg::RST_ADDRESS_HIGH;
    end
    else if (word_done)
    begin
      addr_high_r[5:0] <= word_addr_nxt[13:8];
      addr_low_r <= word_addr_nxt[7:0];
    end
    else if (!seq_busy && wr_low)
    begin
      // Moving the address under a running sequence would corrupt it, so writes while busy are dropped
      if (avs_address == flash_ctrl_pkg::IDX_ADDRESS_LOW)
        addr_low_r <= wr_byte;
      if (avs_address == flash_ctrl_pkg::IDX_ADDRESS_HIGH)
        addr_high_r <= wr_byte;
    end
  end

  // Start requests live one cycle; a wake-up throws them away
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      start_write_r <= 1'b0;
      start_erase_r <= 1'b0;
    end
    else if (deep_sleep_wake)
    begin
      start_write_r <= 1'b0;
      start_erase_r <= 1'b0;
    end
    else if (ctrl_wr && !seq_busy && !start_write_r && !start_erase_r)
    begin
      start_write_r <= wr_byte[flash_ctrl_pkg::BIT_WRITE];
      start_erase_r <= wr_byte[flash_ctrl_pkg::BIT_ERASE];
    end
    else
    begin
      start_write_r <= 1'b0;
      start_erase_r <= 1'b0;
    end
  end

  // Sequencer
  assign tif.run = erase_en_r | program_en_r;
  assign tif.timing = timing_r[5:0];
  assign word_done = (state_r == flash_ctrl_pkg::ST_PROGRAM) && tif.tick
    && (tick_cnt_r == 10'(flash_ctrl_pkg::PROGRAM_TICKS - 1));

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= flash_ctrl_pkg::ST_IDLE;
      seq_write_r <= 1'b0;
      byte_phase_r <= 1'b0;
      wdata_r <= 16'h0000;
      tick_cnt_r <= 10'h000;
      tmo_cnt_r <= 16'h0000;
      erase_en_r <= 1'b0;
      program_en_r <= 1'b0;
      dma_req_r <= 1'b0;
      event_r <= 3'h0;
    end
    else
    begin
      dma_req_r <= 1'b0;
      event_r <= 3'h0;
      unique case (state_r)
        flash_ctrl_pkg::ST_IDLE:
        begin
          if (start_erase_r)
          begin
            state_r <= flash_ctrl_pkg::ST_ERASE;
            seq_write_r <= start_write_r;
            erase_en_r <= 1'b1;
            tick_cnt_r <= 10'h000;
          end
          else if (start_write_r)
          begin
            state_r <= flash_ctrl_pkg::ST_WAIT_DATA;
            byte_phase_r <= 1'b0;
            tmo_cnt_r <= 16'h0000;
            dma_req_r <= 1'b1;
          end
        end
        flash_ctrl_pkg::ST_ERASE:
        begin
          if (tif.tick)
          begin
            if (tick_cnt_r == 10'(flash_ctrl_pkg::ERASE_TICKS - 1))
            begin
              erase_en_r <= 1'b0;
              event_r[flash_ctrl_pkg::IRQ_ERASE_DONE] <= 1'b1;
              byte_phase_r <= 1'b0;
              tmo_cnt_r <= 16'h0000;
              if (seq_write_r)
              begin
                state_r <= flash_ctrl_pkg::ST_WAIT_DATA;
                dma_req_r <= 1'b1;
              end
              else
                state_r <= flash_ctrl_pkg::ST_IDLE;
            end
            else
              tick_cnt_r <= tick_cnt_r + 10'h001;
          end
        end
        flash_ctrl_pkg::ST_WAIT_DATA:
        begin
          if (data_wr && !byte_phase_r)
          begin
            wdata_r[7:0] <= wr_byte;
            byte_phase_r <= 1'b1;
            dma_req_r <= 1'b1;
            tmo_cnt_r <= tmo_cnt_r + 16'h0001;
          end
          else if (data_wr)
          begin
            wdata_r[15:8] <= wr_byte;
            state_r <= flash_ctrl_pkg::ST_PROGRAM;
            program_en_r <= 1'b1;
            tick_cnt_r <= 10'h000;
          end
          else if (tmo_cnt_r >= 16'(TIMEOUT_CYCLES - 1))
          begin
            state_r <= flash_ctrl_pkg::ST_IDLE;
            event_r[flash_ctrl_pkg::IRQ_TIMEOUT] <= 1'b1;
          end
          else
            tmo_cnt_r <= tmo_cnt_r + 16'h0001;
        end
        flash_ctrl_pkg::ST_PROGRAM:
        begin
          if (word_done)
          begin
            program_en_r <= 1'b0;
            state_r <= flash_ctrl_pkg::ST_WAIT_DATA;
            event_r[flash_ctrl_pkg::IRQ_WORD_DONE] <= 1'b1;
            byte_phase_r <= 1'b0;
            tmo_cnt_r <= 16'h0000;
            dma_req_r <= 1'b1;
          end
          else if (tif.tick)
            tick_cnt_r <= tick_cnt_r + 10'h001;
        end
      endcase
    end
  end

  // Flash array drive
  assign flash_read_en = continuous_read_enable_r | flash_read_req;
  assign flash_erase_en = erase_en_r;
  assign flash_program_en = program_en_r;
  assign flash_page = addr_high_r[5:1];
  assign flash_word = {addr_high_r[0], addr_low_r};
  assign flash_wdata = wdata_r;
  assign dma_req = dma_req_r;

  // Interrupts
  assign irq_clear = (wr_low && avs_address == flash_ctrl_pkg::IDX_IRQ_CLEAR) ? wr_byte[2:0]
    : 3'h0;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      irq_enable_r <= 3'h0;
    else if (wr_low && avs_address == flash_ctrl_pkg::IDX_IRQ_ENABLE)
      irq_enable_r <= wr_byte[2:0];
  end

  for (genvar i = 0; i < flash_ctrl_pkg::IRQ_COUNT; i++)
  begin : g_irq
    sticky_flag u_flag (
      .core_clk(core_clk),
      .rst(rst),
      .set(event_r[i]),
      .clr(irq_clear[i]),
      .flag(irq_status[i])
    );
  end

  assign irq = |(irq_status & irq_enable_r);

endmodule

// ### tb/flash_ctrl_properties.sv
// Port-level checker of the flash program/erase controller
`timescale 1ns/1ps
module flash_ctrl_properties #(
  parameter int TIMEOUT_CYCLES = 8000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Power, flash, dma, interrupt
  input wire logic deep_sleep_wake,
  input wire logic flash_read_req,
  input wire logic flash_read_en,
  input wire logic flash_erase_en,
  input wire logic flash_program_en,
  input wire logic [4:0] flash_page,
  input wire logic [8:0] flash_word,
  input wire logic [15:0] flash_wdata,
  input wire logic dma_req,
  input wire logic irq
);
  logic data_wr;
  logic erase_wr;
  logic taken;
  assign taken = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign data_wr = taken && avs_address == flash_ctrl_pkg::IDX_WRITE_DATA_PORT;
  assign erase_wr = taken && avs_address == flash_ctrl_pkg::IDX_CONTROL_STATUS && avs_writedata[0];
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest held too long");
  property p_read_en;
    flash_read_req |-> flash_read_en;
  endproperty
  a_read_en: assert property (p_read_en) else $error("read enable gated on request");
  property p_prog_cause;
    $rose(flash_program_en) |-> $past(data_wr) || $past(data_wr, 2);
  endproperty
  a_prog_cause: assert property (p_prog_cause) else $error("program without byte");
  // Bound assumes write_timing at or below its reset value
  property p_prog_len;
    $rose(flash_program_en) |-> ##[1:600] !flash_program_en;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("word program never ends");
  property p_excl;
    !(flash_erase_en && flash_program_en);
  endproperty
  a_excl: assert property (p_excl) else $error("erase and program overlap");
  property p_dma;
    dma_req |=> !dma_req;
  endproperty
  a_dma: assert property (p_dma) else $error("dma request longer than a cycle");
  property p_erase_cause;
    $rose(flash_erase_en) |-> $past(erase_wr, 2) || $past(erase_wr, 3) || $past(erase_wr, 4);
  endproperty
  a_erase_cause: assert property (p_erase_cause) else $error("erase without start");
  property p_erase_len;
    $rose(flash_erase_en) |=> flash_erase_en [*8];
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase too short");
  property p_rd_upper;
    avs_readdata[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
  c_erase: cover property ($rose(flash_erase_en));
  c_prog: cover property ($rose(flash_program_en));
  c_irq: cover property ($rose(irq));
endmodule

bind flash_program_erase_control flash_ctrl_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (
  .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .deep_sleep_wake(deep_sleep_wake), .flash_read_req(flash_read_req),
  .flash_read_en(flash_read_en), .flash_erase_en(flash_erase_en),
  .flash_program_en(flash_program_en), .flash_page(flash_page), .flash_word(flash_word),
  .flash_wdata(flash_wdata), .dma_req(dma_req), .irq(irq));

// ### tb/flash_array_model.sv
// Behavioural flash array behind the controller
`timescale 1ns/1ps
module flash_array_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Controller side
  input wire logic flash_erase_en,
  input wire logic flash_program_en,
  input wire logic [4:0] flash_page,
  input wire logic [8:0] flash_word,
  input wire logic [15:0] flash_wdata,
  input wire logic dma_req,
  output logic flash_read_req
);
  logic [15:0] mem [logic [13:0]];
  int erase_cnt;
  int dma_cnt;
  logic erase_q;
  logic prog_q;
  logic [13:0] k;
  // Fetch requests toggle so gated reads get exercised
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      flash_read_req <= 1'b0;
      erase_q <= 1'b0;
      prog_q <= 1'b0;
      erase_cnt <= 0;
      dma_cnt <= 0;
    end
    else
    begin
      flash_read_req <= ~flash_read_req;
      erase_q <= flash_erase_en;
      prog_q <= flash_program_en;
      if (dma_req)
        dma_cnt <= dma_cnt + 1;
      if (flash_erase_en && !erase_q)
      begin
        erase_cnt <= erase_cnt + 1;
        for (int i = 0; i < 512; i++)
          mem[{flash_page, i[8:0]}] = 16'hffff;
      end
      // Programming only clears bits, as real cells do
      k = {flash_page, flash_word};
      if (flash_program_en && !prog_q)
        mem[k] = (mem.exists(k) ? mem[k] : 16'hffff) & flash_wdata;
    end
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench of the flash program/erase controller
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] WT = flash_ctrl_pkg::IDX_WRITE_TIMING;
  localparam logic [7:0] AL = flash_ctrl_pkg::IDX_ADDRESS_LOW;
  localparam logic [7:0] AH = flash_ctrl_pkg::IDX_ADDRESS_HIGH;
  localparam logic [7:0] CTL = flash_ctrl_pkg::IDX_CONTROL_STATUS;
  localparam logic [7:0] WD = flash_ctrl_pkg::IDX_WRITE_DATA_PORT;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic deep_sleep_wake = 1'b0;
  logic flash_read_req;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic flash_read_en;
  logic flash_erase_en;
  logic flash_program_en;
  logic [4:0] flash_page;
  logic [8:0] flash_word;
  logic [15:0] flash_wdata;
  logic dma_req;
  logic irq;
  int n_fail = 0;
  int compares = 0;
  int n;
  always #2.5 core_clk = ~core_clk;
  flash_program_erase_control #(.TIMEOUT_CYCLES(200)) dut (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .deep_sleep_wake(deep_sleep_wake), .flash_read_req(flash_read_req),
    .flash_read_en(flash_read_en), .flash_erase_en(flash_erase_en),
    .flash_program_en(flash_program_en), .flash_page(flash_page), .flash_word(flash_word),
    .flash_wdata(flash_wdata), .dma_req(dma_req), .irq(irq));
  flash_array_model model (
    .core_clk(core_clk), .rst(rst), .flash_erase_en(flash_erase_en),
    .flash_program_en(flash_program_en), .flash_page(flash_page), .flash_word(flash_word),
    .flash_wdata(flash_wdata), .dma_req(dma_req), .flash_read_req(flash_read_req));
  task automatic print_verdict();
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One Avalon access; request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int w;
    w = 0;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge core_clk);
      w++;
    end
    while (avs_waitrequest !== 1'b0 && w < 50);
    if (w >= 50)
    begin
      n_fail++;
      print_verdict();
    end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // One idle edge keeps a following request from landing in the same time step
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, exp});
  endtask
  task automatic wait_ctl(input logic [7:0] mask, input logic [7:0] val);
    logic [7:0] q;
    int w;
    w = 0;
    do
    begin
      bus(1'b0, CTL, 8'h00, q);
      w++;
    end
    while ((q & mask) !== val && w < 8000);
    if (w >= 8000)
    begin
      n_fail++;
      print_verdict();
    end
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(WT, 8'h11);
    rd(AL, 8'h00);
    rd(AH, 8'h00);
    rd(CTL, 8'h00);
    rd(WD, 8'h00);
    rd(8'hc0, 8'h00);
    wr(AH, 8'h3f);
    rd(AH, 8'h3f);
    wr(AL, 8'ha5);
    rd(AL, 8'ha5);
    avs_byteenable <= 4'he;
    wr(AL, 8'h5a);
    avs_byteenable <= 4'h1;
    rd(AL, 8'ha5);
    wr(CTL, 8'h10);
    rd(CTL, 8'h10);
    repeat (3)
    begin
      @(posedge core_clk);
      chk({15'h0000, flash_read_en}, 16'h0001);
    end
    wr(CTL, 8'h00);
    repeat (2)
    begin
      @(posedge core_clk);
      chk({15'h0000, flash_read_en}, {15'h0000, flash_read_req});
    end
    wr(WT, 8'h01);
    wr(AH, 8'h04);
    wr(CTL, 8'h01);
    rd(CTL, 8'h80);
    chk({11'h000, flash_page}, 16'h0002);
    wait_ctl(8'h80, 8'h00);
    chk(model.mem[{5'd2, 9'd7}], 16'hffff);
    rd(8'hb0, 8'h01);
    wr(8'hb2, 8'h01);
    chk({15'h0000, irq}, 16'h0001);
    wr(8'hb1, 8'h01);
    chk({15'h0000, irq}, 16'h0000);
    wr(AH, 8'h05);
    wr(AL, 8'hff);
    wr(CTL, 8'h02);
    rd(CTL, 8'h80);
    wr(WD, 8'h34);
    wr(WD, 8'h12);
    wait_ctl(8'h40, 8'h00);
    chk(model.mem[{5'd2, 9'd511}], 16'h1234);
    rd(AL, 8'h00);
    rd(AH, 8'h06);
    rd(CTL, 8'h80);
    rd(8'hb0, 8'h02);
    chk({15'h0000, irq}, 16'h0000);
    wait_ctl(8'h80, 8'h00);
    rd(AL, 8'h00);
    rd(AH, 8'h06);
    rd(8'hb0, 8'h06);
    chk(16'(model.dma_cnt), 16'h0003);
    wr(AH, 8'h04);
    wr(AL, 8'h10);
    wr(CTL, 8'h03);
    wr(AL, 8'hee);
    // Bytes are only supplied once the erase has ended
    n = 0;
    while ((model.erase_cnt < 2 || flash_erase_en) && n < 20000)
    begin
      @(posedge core_clk);
      n++;
    end
    chk({15'h0000, n < 20000}, 16'h0001);
    if (n >= 20000)
      print_verdict();
    rd(CTL, 8'h80);
    wr(WD, 8'h78);
    wr(WD, 8'h56);
    wait_ctl(8'h40, 8'h00);
    chk(model.mem[{5'd2, 9'h010}], 16'h5678);
    wait_ctl(8'h80, 8'h00);
    rd(AL, 8'h11);
    // Wake is held across the start so the pending request is hit
    deep_sleep_wake <= 1'b1;
    wr(CTL, 8'h02);
    deep_sleep_wake <= 1'b0;
    rd(CTL, 8'h00);
    print_verdict();
  end
endmodule
